/* File: hdl/credential_code_decoder.sv */
`timescale 1ns/1ps
module credential_code_decoder #(
   parameter int WORD  = ccd_pkg::WORD_BITS,
   parameter int DIV   = ccd_pkg::CARRIER_DIV,
   parameter int HOLD  = ccd_pkg::HALF_PERIOD_CLKS * 3,
   // bit periods without a burst before the credential counts as gone
   parameter int QUIET = ccd_pkg::WORD_BITS
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        carrier_tone,
   input  wire logic        burst_pulse,
   input  wire logic        envelope_ok,
   input  wire logic        xmit_req,
   output logic             data_valid,
   output logic [15:0]      held_code,
   output logic             held_full,
   output logic             code_out_stb,
   output logic [15:0]      code_out,
   output logic             credential_present
);
   typedef enum logic [1:0] {
      CCD_FILL  = 2'b00,
      CCD_CHECK = 2'b01,
      CCD_DONE  = 2'b10
   } ccd_state_e;

   ccd_state_e          state_reg;
   logic                bit_tick;
   logic                data_bit;
   logic                sample_reg;
   logic [WORD-1:0]     reg1_reg;
   logic [WORD-1:0]     reg2_reg;
   logic [5:0]          fill_reg;
   logic [5:0]          quiet_reg;
   logic [15:0]         code1;
   logic [15:0]         code2;
   logic                par_ok;
   logic                sync_ok;
   logic                cmp_ok;
   logic                check_pass;

   ccd_edge_div #(
      .DIV (DIV)
   ) u_div (
      .clk_sys (clk_sys),
      .rst     (rst),
      .tone_in (carrier_tone),
      .tick    (bit_tick)
   );

   ccd_oneshot #(
      .HOLD (HOLD)
   ) u_burst_stretch_oneshot (
      .clk_sys (clk_sys),
      .rst     (rst),
      .trig    (burst_pulse),
      .gate    (envelope_ok),
      .level   (data_bit)
   );

   // a bit is a one if the stretched level was seen at any time in the period,
   // which tolerates the phase slip between burst and local bit clock
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sample_reg <= 1'b0;
      end else if (bit_tick) begin
         sample_reg <= data_bit;
      end else if (data_bit) begin
         sample_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg1_reg <= '0;
         reg2_reg <= '0;
      end else if (bit_tick) begin
         reg1_reg <= {reg1_reg[WORD-2:0], sample_reg};
         reg2_reg <= {reg2_reg[WORD-2:0], reg1_reg[WORD-1]};
      end
   end

   // code bits: the two eight-bit spans that start at each sync bit
   assign code1 = {reg1_reg[ccd_pkg::SUB_LO_BIT+:ccd_pkg::SUB_SPAN],
                   reg1_reg[ccd_pkg::SUB_HI_BIT+:ccd_pkg::SUB_SPAN]};
   assign code2 = {reg2_reg[ccd_pkg::SUB_LO_BIT+:ccd_pkg::SUB_SPAN],
                   reg2_reg[ccd_pkg::SUB_HI_BIT+:ccd_pkg::SUB_SPAN]};

   assign cmp_ok  = (code1 == code2);
   assign par_ok  = ~^reg1_reg[ccd_pkg::SUB_LO_BIT+:ccd_pkg::SUB_SPAN]
                  & ~^reg1_reg[ccd_pkg::SUB_HI_BIT+:ccd_pkg::SUB_SPAN]
                  & ~^reg2_reg[ccd_pkg::SUB_LO_BIT+:ccd_pkg::SUB_SPAN]
                  & ~^reg2_reg[ccd_pkg::SUB_HI_BIT+:ccd_pkg::SUB_SPAN];
   assign sync_ok = (reg1_reg[ccd_pkg::SUB_LO_BIT] == ccd_pkg::SYNC_LO_VAL)
                  & (reg1_reg[ccd_pkg::SUB_HI_BIT] == ccd_pkg::SYNC_HI_VAL)
                  & (reg2_reg[ccd_pkg::SUB_LO_BIT] == ccd_pkg::SYNC_LO_VAL)
                  & (reg2_reg[ccd_pkg::SUB_HI_BIT] == ccd_pkg::SYNC_HI_VAL);
   assign check_pass = cmp_ok & par_ok & sync_ok;

   // presence: any one bit in the last QUIET periods
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         quiet_reg          <= 6'h00;
         credential_present <= 1'b0;
      end else if (bit_tick) begin
         if (sample_reg) begin
            quiet_reg          <= 6'(QUIET);
            credential_present <= 1'b1;
         end else if (quiet_reg != 6'h00) begin
            quiet_reg <= quiet_reg - 6'h01;
         end else begin
            credential_present <= 1'b0;
         end
      end
   end

   // sequencing: fill 48 periods, then check every period until pass or loss
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= CCD_FILL;
         fill_reg  <= 6'h00;
      end else if (bit_tick) begin
         unique case (state_reg)
            CCD_FILL: begin
               if (fill_reg == 6'(ccd_pkg::FILL_PERIODS - 1)) begin
                  state_reg <= CCD_CHECK;
               end else begin
                  fill_reg <= fill_reg + 6'h01;
               end
            end
            CCD_CHECK: begin
               if (check_pass) begin
                  state_reg <= CCD_DONE;
               end else if (!credential_present) begin
                  state_reg <= CCD_FILL;
                  fill_reg  <= 6'h00;
               end
            end
            CCD_DONE: begin
               // one report per passage; rearm once the credential is gone
               if (!credential_present) begin
                  state_reg <= CCD_FILL;
                  fill_reg  <= 6'h00;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         data_valid <= 1'b0;
      end else begin
         data_valid <= bit_tick & (state_reg == CCD_CHECK) & check_pass;
      end
   end

   // holding register: only overwritten by a later valid event
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         held_code <= ccd_pkg::CODE_RST;
      end else if (bit_tick & (state_reg == CCD_CHECK) & check_pass) begin
         held_code <= code1;
      end
   end

   // full flag: a new load wins over a read request in the same cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         held_full <= 1'b0;
      end else if (bit_tick & (state_reg == CCD_CHECK) & check_pass) begin
         held_full <= 1'b1;
      end else if (xmit_req) begin
         held_full <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         code_out_stb <= 1'b0;
         code_out     <= ccd_pkg::CODE_RST;
      end else begin
         code_out_stb <= xmit_req & held_full;
         if (xmit_req & held_full) begin
            code_out <= held_code;
         end
      end
   end
endmodule

/* File: shared/ccd_pkg.sv */
package ccd_pkg;
   // link timing, derived from the 110 kHz portal tone and the 125 MHz system clock
   localparam int CARRIER_HZ       = 110000;
   localparam int CARRIER_DIV      = 64;
   localparam int BURST_CYCLES     = 32;
   localparam int SYS_HZ           = 125000000;
   // one 55 kHz half period in system clocks, rounded up for retrigger hold
   localparam int HALF_PERIOD_NS   = 9091;
   localparam int HALF_PERIOD_CLKS = (HALF_PERIOD_NS * 125 + 999) / 1000;
   // code word layout
   localparam int WORD_BITS        = 24;
   localparam int SUB_LO_BIT       = 2;
   localparam int SUB_HI_BIT       = 14;
   localparam int SUB_SPAN         = 8;
   localparam int CODE_BITS        = 16;
   localparam int FILL_PERIODS     = 48;
   localparam int ALIGN_PERIODS    = 23;
   localparam int GROWTH_PERIODS   = 24;
   localparam int ALLOW_MS         = 56;
   localparam logic SYNC_LO_VAL    = 1'b1;
   localparam logic SYNC_HI_VAL    = 1'b0;
   localparam logic [15:0] CODE_RST = 16'h0000;
endpackage

/* File: hdl/ccd_edge_div.sv */
`timescale 1ns/1ps
// edge detector plus divide-by-n on the carrier tone input
module ccd_edge_div #(
   parameter int DIV = ccd_pkg::CARRIER_DIV
) (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic tone_in,
   output logic      tick
);
   logic       tone_d_reg;
   logic [5:0] cnt_reg;
   wire        rise = tone_in & ~tone_d_reg;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         // track the pin in reset so a high tone is no false edge after release
         tone_d_reg <= tone_in;
      end else begin
         tone_d_reg <= tone_in;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_reg <= 6'h00;
         tick    <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (rise) begin
            cnt_reg <= cnt_reg + 6'h01;
            if (cnt_reg == 6'(DIV - 1)) begin
               cnt_reg <= 6'h00;
               tick    <= 1'b1;
            end
         end
      end
   end
endmodule

/* File: hdl/ccd_oneshot.sv */
`timescale 1ns/1ps
// retriggerable one-shot that stretches a pulse burst into one level
module ccd_oneshot #(
   parameter int HOLD = ccd_pkg::HALF_PERIOD_CLKS * 3
) (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic trig,
   input  wire logic gate,
   output logic      level
);
   logic [11:0] cnt_reg;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_reg <= 12'h000;
         level   <= 1'b0;
      end else begin
         // every pulse reloads, so with gate high the output falls only after the last one
         if (trig) begin
            cnt_reg <= 12'(HOLD);
         end else if (cnt_reg != 12'h000) begin
            cnt_reg <= cnt_reg - 12'h001;
         end
         level <= gate & (trig | (cnt_reg > 12'h001));
      end
   end
endmodule

/* File: tb/ccd_chk_sva.sv */
`timescale 1ns/1ps
module ccd_chk (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        xmit_req,
   input wire logic        data_valid,
   input wire logic [15:0] held_code,
   input wire logic        held_full,
   input wire logic        code_out_stb,
   input wire logic [15:0] code_out
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   valid_sync_a: assert property (data_valid |-> held_code[8] && !held_code[0])
      else $error("sync bit wrong on valid");
   valid_parity_a: assert property (data_valid |-> !(^held_code[15:8]) && !(^held_code[7:0]))
      else $error("odd parity on valid");
   valid_loads_a: assert property (data_valid |-> held_full)
      else $error("valid without holding load");
   code_hold_a: assert property (!data_valid |-> $stable(held_code))
      else $error("held code changed without valid");
   single_valid_a: assert property (data_valid |=> !data_valid [*8])
      else $error("valid repeated");
   read_serve_a: assert property (xmit_req && held_full |=> code_out_stb && code_out == $past(held_code))
      else $error("read not served");
   read_refuse_a: assert property (!held_full |=> !code_out_stb)
      else $error("read served while empty");
   read_clear_a: assert property (xmit_req && held_full |=> !held_full || data_valid)
      else $error("holding not emptied by read");
   out_hold_a: assert property (!code_out_stb |-> $stable(code_out))
      else $error("read data changed without strobe");
endmodule
bind credential_code_decoder ccd_chk u_chk (.clk_sys, .rst, .xmit_req, .data_valid,
   .held_code, .held_full, .code_out_stb, .code_out);

/* File: tb/ccd_card_model.sv */
`timescale 1ns/1ps
module ccd_card_model (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        active,
   input  wire logic        env_en,
   input  wire logic [23:0] word,
   output logic             carrier_tone,
   output logic             burst_pulse,
   output logic             envelope_ok
);
   logic [3:0] ph_reg;
   logic       half_reg;
   logic [4:0] idx_reg;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ph_reg <= 4'h0;
      end else begin
         ph_reg <= ph_reg + 4'h1;
      end
   end
   // two carrier periods per bit, matching the test divider
   always_ff @(posedge clk_sys) begin
      if (rst || !active) begin
         half_reg <= 1'b0;
         idx_reg  <= 5'h17;
      end else if (ph_reg == 4'hF) begin
         half_reg <= ~half_reg;
         if (half_reg) begin
            idx_reg <= (idx_reg == 5'h0) ? 5'h17 : idx_reg - 5'h1;
         end
      end
   end
   assign carrier_tone = ~ph_reg[3];
   // shortened burst in the carrier low phase, so no bit boundary splits it
   // word stands in for the strapped row matrix of the card
   assign burst_pulse  = active && word[idx_reg] && !half_reg && ph_reg[3]
                         && ph_reg[2:0] inside {3'h1, 3'h2};
   assign envelope_ok  = active && env_en;
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        xmit_req = 1'b0;
   logic        active = 1'b0;
   logic        env_en = 1'b1;
   logic [23:0] word = 24'h0;
   logic        carrier_tone, burst_pulse, envelope_ok, data_valid, held_full;
   logic        code_out_stb, credential_present;
   logic [15:0] held_code, code_out;
   int          n_fail = 0;
   int          n_compared = 0;
   int          cyc = 0;
   int          nv;
   initial forever #4 clk_sys = ~clk_sys;
   ccd_card_model u_card (.clk_sys, .rst, .active, .env_en, .word, .carrier_tone,
      .burst_pulse, .envelope_ok);
   credential_code_decoder #(.DIV(2), .HOLD(2)) u_dut (.clk_sys, .rst, .carrier_tone,
      .burst_pulse, .envelope_ok, .xmit_req, .data_valid, .held_code, .held_full,
      .code_out_stb, .code_out, .credential_present);
   task automatic test_done();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // card in field for n clocks, then removed; the caller waits for the rearm
   task automatic run(input logic [23:0] w, input logic e, input int n);
      word <= w;
      env_en <= e;
      active <= 1'b1;
      nv = 0;
      repeat (n) begin
         @(posedge clk_sys);
         nv += int'(data_valid === 1'b1);
      end
      active <= 1'b0;
   endtask
   task automatic t_reject(input logic [23:0] w, input logic e);
      run(w, e, 4000);
      chk(16'(nv), 16'h0);
      repeat (900) @(posedge clk_sys);
      $display("reject test done");
   endtask
   task automatic t_accept(input logic [23:0] w, input logic [15:0] code);
      run(w, 1'b1, 4000);
      chk(16'(nv), 16'h1);
      chk(held_code, code);
      chk(16'(held_full), 16'h1);
      chk(16'(credential_present), 16'h1);
      repeat (900) @(posedge clk_sys);
      chk(16'(credential_present), 16'h0);
      chk(held_code, code);
      $display("accept test done");
   endtask
   task automatic req();
      @(posedge clk_sys);
      xmit_req <= 1'b1;
      @(posedge clk_sys);
      xmit_req <= 1'b0;
      @(negedge clk_sys);
   endtask
   task automatic t_read(input logic [15:0] code);
      req();
      chk(16'(code_out_stb), 16'h1);
      chk(code_out, code);
      chk(16'(held_full), 16'h0);
      req();
      chk(16'(code_out_stb), 16'h0);
      $display("read test done");
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail++;
         test_done();
      end
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      t_reject(24'h000004, 1'b1);
      t_reject(24'h018208, 1'b1);
      t_reject(24'h018204, 1'b0);
      t_accept(24'h018204, 16'h8106);
      t_read(16'h8106);
      t_accept(24'h028104, 16'h410A);
      test_done();
   end
endmodule
